// *** sim/pulse_template_ram_access_tb.sv ***
// Self-checking bench for the template RAM register bank.
`timescale 1ns/10ps
module pulse_template_ram_access_tb
  import pulse_template_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] play_addr = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wave_out_t wave_out;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int check_count = 0;
  logic [5:0] codes [5] = '{factor_t1, factor_ds1_m7, factor_ds1_m15,
    factor_ds1_m22, factor_e1};
  logic [5:0] idx [4] = '{6'h00, 6'h0f, 6'h30, 6'h3f};
  logic [6:0] dat [4] = '{7'h55, 7'h2a, 7'h7f, 7'h01};
  logic [3:0] sels [4] = '{select_e1_75_int, select_e1_75_ext, 4'hb,
    4'hf};

  // Clock of 100 ns period.
  initial
  begin
    forever #50 pclk = ~pclk;
  end

  pulse_template_ram_access dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .play_addr(play_addr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wave_out(wave_out)
  );

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Starts an indirect access and polls until the trigger bit clears.
  task automatic ram_op(input logic rdir, input logic [5:0] i);
    int n;
    n = 0;
    apb(1'b1, addr_access, {24'h0, 1'b1, rdir, i});
    do
    begin
      apb(1'b0, addr_access, 32'h0);
      n++;
    end
    while (rd[7] !== 1'b0 && n < 8);
    chk(rd, {24'h0, 1'b0, rdir, i});
  endtask

  // Checks the waveform output for one played sample.
  task automatic wchk(input logic [5:0] i, input logic [13:0] exp);
    play_addr <= i;
    repeat (3) @(posedge pclk);
    chk({18'h0, wave_out}, {18'h0, exp});
  endtask

  // Prints counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence of register and template tests.
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(addr_scale, 32'h21);
    rchk(addr_access, 32'h0);
    chk({31'h0, err}, 32'h0);
    foreach (codes[i])
    begin
      apb(1'b1, addr_scale, {26'h0, codes[i]});
      rchk(addr_scale, {26'h0, codes[i]});
    end
    foreach (idx[i])
    begin
      apb(1'b1, addr_data, {25'h0, dat[i]});
      ram_op(1'b0, idx[i]);
    end
    foreach (idx[i])
    begin
      apb(1'b1, addr_data, 32'h0);
      ram_op(1'b1, idx[i]);
      rchk(addr_data, {25'h0, dat[i]});
    end
    apb(1'b1, addr_select, 32'hc);
    foreach (idx[i])
      wchk(idx[i], {1'b1, 6'h21, dat[i]});
    apb(1'b1, addr_scale, 32'h04);
    wchk(6'h30, {1'b1, 6'h04, 7'h0f});
    apb(1'b1, addr_scale, 32'h36);
    wchk(6'h00, {1'b1, 6'h36, 7'h7f});
    foreach (sels[i])
    begin
      apb(1'b1, addr_select, {28'h0, sels[i]});
      repeat (3) @(posedge pclk);
      chk({31'h0, wave_out.user_wave}, {31'h0, &sels[i][3:2]});
    end
    apb(1'b1, 12'h100, 32'hff);
    chk({31'h0, err}, 32'h1);
    rchk(12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    // A second reset in mid-run brings the registers back to defaults.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({18'h0, wave_out}, 32'h0);
    presetn <= 1'b1;
    rchk(addr_scale, {26'h0, factor_reset});
    rchk(addr_access, 32'h0);
    complete_run;
  end

  // Watchdog against a hung handshake.
  initial
  begin
    #(3000 * 100);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run;
  end
endmodule // pulse_template_ram_access_tb

// *** verilog/pulse_template_pkg.sv ***
// Package of offsets, fields, reset values and types for the template block.
// Functional notes
// - Template select 11xx uses RAM waveform.
// - Six-bit factor scales arbitrary pulses, reset 100001.
// - T1, J1, DS1 0 dB: nominal 110110, 2%.
// - DS1 -7.5 dB: nominal 010001, 6.25%.
// - DS1 -15 dB: nominal 001000, 12.5%.
// - DS1 -22.5 dB: nominal 000100, 25%.
// - E1 templates: nominal 100001, 3%.
// - Writing trigger bit starts one access.
// - Direction bit: zero writes, one reads.
// - Two-bit index picks one of four intervals.
// - Four-bit index picks one of sixteen samples.
// - Indirect write stores data word in RAM.
// - Indirect read returns sample into data register.
package pulse_template_pkg;
  // Register indexes; each byte address is four times its index.
  localparam logic [9:0] index_select = 10'h006;
  localparam logic [9:0] index_scale = 10'h007;
  localparam logic [9:0] index_access = 10'h008;
  localparam logic [9:0] index_data = 10'h009;
  localparam logic [11:0] addr_scale = {index_scale, 2'b00};
  localparam logic [11:0] addr_access = {index_access, 2'b00};
  localparam logic [11:0] addr_data = {index_data, 2'b00};
  localparam logic [11:0] addr_select = {index_select, 2'b00};
  localparam logic [5:0] factor_reset = 6'h21;
  localparam logic [5:0] factor_t1 = 6'h36;
  localparam logic [5:0] factor_ds1_m7 = 6'h11;
  localparam logic [5:0] factor_ds1_m15 = 6'h08;
  localparam logic [5:0] factor_ds1_m22 = 6'h04;
  localparam logic [5:0] factor_e1 = 6'h21;
  localparam logic [3:0] select_reset = 4'h0;
  localparam logic [3:0] select_e1_75_int = 4'h0;
  localparam logic [3:0] select_e1_75_ext = 4'h1;
  localparam logic [1:0] select_user_top = 2'h3;
  localparam int trigger_bit = 7;
  localparam int dir_bit = 6;
  localparam int interval_lsb = 4;
  localparam int slot_lsb = 0;
  localparam int ram_depth = 64;

  // Indirect access control fields.
  typedef struct packed {
    logic trigger;
    logic read_dir;
    logic [1:0] interval_index;
    logic [3:0] subinterval_slot;
  } access_ctrl_t;

  // Waveform output presented to the shaper.
  typedef struct packed {
    logic user_wave;
    logic [5:0] amplitude_factor;
    logic [6:0] scaled_sample;
  } wave_out_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_write = 2'b01,
    st_read = 2'b10
  } access_state_t;
endpackage

// *** verilog/pulse_template_ram_access.sv ***
// APB register bank with indirect access to the pulse template RAM.
`timescale 1ns/10ps
module pulse_template_ram_access
  import pulse_template_pkg::*;
(
  input wire logic pclk, // System clock, 10 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [5:0] play_addr, // Sample being played by the shaper.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output wave_out_t wave_out // Registered waveform to the shaper.
);

  logic [5:0] amplitude_factor;
  logic [3:0] line_template_select;
  access_ctrl_t ctrl;
  logic [6:0] template_amplitude_word;
  access_state_t state;
  logic [6:0] ram [ram_depth];
  logic [5:0] next_amplitude_factor;
  logic [3:0] next_line_template_select;
  access_ctrl_t next_ctrl;
  logic [6:0] next_template_amplitude_word;
  access_state_t next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  wave_out_t next_wave_out;
  logic access_wr;
  logic setup_rd;
  logic [6:0] play_word;
  logic [12:0] product;

  // Decode a mapped address.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == addr_scale) || (a == addr_access) ||
      (a == addr_data) || (a == addr_select);
  endfunction

  // RAM index from interval and slot.
  function automatic logic [5:0] ram_index(input access_ctrl_t c);
    ram_index = {c.interval_index, c.subinterval_slot};
  endfunction

  // Reads are decoded in the setup cycle so their data stand with pready.
  // Writes land only at the access edge where pready is sampled high.
  assign access_wr = psel && penable && pready && pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  // Register and access engine next state.
  always_comb
  begin
    next_amplitude_factor = amplitude_factor;
    next_line_template_select = line_template_select;
    next_ctrl = ctrl;
    next_template_amplitude_word = template_amplitude_word;
    next_state = state;
    next_prdata = 32'h0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_pready = 1'b1;
      next_pslverr = !mapped(paddr);
    end
    unique case (state)
      st_idle:
      begin
      end
      st_write:
      begin
        next_ctrl.trigger = 1'b0;
        next_state = st_idle;
      end
      st_read:
      begin
        next_template_amplitude_word = ram[ram_index(ctrl)];
        next_ctrl.trigger = 1'b0;
        next_state = st_idle;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
    if (access_wr)
    begin
      unique case (paddr)
        addr_scale:
        begin
          next_amplitude_factor = pwdata[5:0];
        end
        addr_select:
        begin
          next_line_template_select = pwdata[3:0];
        end
        addr_access:
        begin
          // Writes during a busy access are ignored.
          if (state == st_idle && !ctrl.trigger)
          begin
            next_ctrl = pwdata[7:0];
            if (pwdata[trigger_bit])
            begin
              next_state = pwdata[dir_bit] ? st_read : st_write;
            end
          end
        end
        addr_data:
        begin
          if (state == st_idle)
          begin
            next_template_amplitude_word = pwdata[6:0];
          end
        end
        default:
        begin
        end
      endcase
    end
    if (setup_rd)
    begin
      unique case (paddr)
        addr_scale: next_prdata = {26'h0, amplitude_factor};
        addr_select: next_prdata = {28'h0, line_template_select};
        addr_access: next_prdata = {24'h0, ctrl};
        addr_data: next_prdata = {25'h0, template_amplitude_word};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // Register stage for the bank and engine.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      amplitude_factor <= factor_reset;
      line_template_select <= select_reset;
      ctrl <= '0;
      template_amplitude_word <= 7'h00;
      state <= st_idle;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      amplitude_factor <= next_amplitude_factor;
      line_template_select <= next_line_template_select;
      ctrl <= next_ctrl;
      template_amplitude_word <= next_template_amplitude_word;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (state == st_write)
    begin
      ram[ram_index(ctrl)] <= template_amplitude_word;
    end
  end

  // Scale the played sample: factor 100001 is treated as unity.
  assign play_word = ram[play_addr];
  assign product = play_word * amplitude_factor;

  // Waveform output next value.
  always_comb
  begin
    next_wave_out.user_wave = line_template_select[3:2] == select_user_top;
    next_wave_out.amplitude_factor = amplitude_factor;
    next_wave_out.scaled_sample = (product / 13'(factor_reset)) > 13'h7f ?
      7'h7f : 7'((product / 13'(factor_reset)));
  end

  // Waveform output register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wave_out <= '0;
    end
    else
    begin
      wave_out <= next_wave_out;
    end
  end

  property p_trigger_clears;
    @(posedge pclk) disable iff (!presetn)
    (state != st_idle) |=> !ctrl.trigger && state == st_idle;
  endproperty
  a_trigger_clears: assert property (p_trigger_clears)
    else $error("trigger not cleared");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (access_wr && paddr == addr_access && pwdata[trigger_bit] &&
     state == st_idle && !ctrl.trigger) |=> state != st_idle;
  endproperty
  a_start: assert property (p_start)
    else $error("access not started");

  property p_dir;
    @(posedge pclk) disable iff (!presetn)
    (state != st_idle) |-> ((state == st_read) == ctrl.read_dir);
  endproperty
  a_dir: assert property (p_dir)
    else $error("wrong direction");

  property p_read_data;
    @(posedge pclk) disable iff (!presetn)
    (state == st_read) |=>
      template_amplitude_word == $past(ram[ram_index(ctrl)]);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data wrong");

  property p_user;
    @(posedge pclk) disable iff (!presetn)
    ##1 wave_out.user_wave == ($past(line_template_select[3:2]) == 2'h3);
  endproperty
  a_user: assert property (p_user)
    else $error("user waveform flag wrong");

  property p_factor;
    @(posedge pclk) disable iff (!presetn)
    (access_wr && paddr == addr_scale) |=>
      amplitude_factor == $past(pwdata[5:0]);
  endproperty
  a_factor: assert property (p_factor)
    else $error("factor not stored");

  // Ready is a single-cycle pulse in the access phase.
  sequence s_ready_pulse;
    pready ##1 !pready;
  endsequence

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> s_ready_pulse;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready timing wrong");

  property p_write_back;
    @(posedge pclk) disable iff (!presetn)
    (state == st_write) |=>
      ram[ram_index($past(ctrl))] == $past(template_amplitude_word);
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("RAM write wrong");

  property p_write_start;
    @(posedge pclk) disable iff (!presetn)
    (access_wr && paddr == addr_access && pwdata[trigger_bit] &&
     !pwdata[dir_bit] && state == st_idle && !ctrl.trigger) |=>
      state == st_write;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("indirect write not started");

  // An accepted read trigger, then one read cycle, then idle.
  sequence s_read_launch;
    access_wr && paddr == addr_access && pwdata[trigger_bit] &&
      pwdata[dir_bit] && state == st_idle && !ctrl.trigger;
  endsequence

  sequence s_read_done;
    state == st_read ##1 (state == st_idle && !ctrl.trigger);
  endsequence

  property p_read_steps;
    @(posedge pclk) disable iff (!presetn)
    s_read_launch |=> s_read_done;
  endproperty
  a_read_steps: assert property (p_read_steps)
    else $error("indirect read steps wrong");

  property p_index_kept;
    @(posedge pclk) disable iff (!presetn)
    (state != st_idle) |=> ctrl[5:0] == $past(ctrl[5:0]);
  endproperty
  a_index_kept: assert property (p_index_kept)
    else $error("access index changed");

  property p_factor_hold;
    @(posedge pclk) disable iff (!presetn)
    !(access_wr && paddr == addr_scale) |=> $stable(amplitude_factor);
  endproperty
  a_factor_hold: assert property (p_factor_hold)
    else $error("factor changed without a write");

endmodule // pulse_template_ram_access
